/* inc/stt_if.sv */
// high-speed split link between host controller and translator
`timescale 1ns/1ps
interface stt_if;
  logic ss_valid;
  logic cs_valid;
  stt_pkg::split_tok_t tok;
  logic [31:0] out_data;
  logic ready;
  logic resp_valid;
  stt_pkg::resp_t resp;
  logic [31:0] in_data;
  logic sof;
  modport host (output ss_valid, output cs_valid, output tok, output out_data,
                output sof, input ready, input resp_valid, input resp, input in_data);
  modport tt (input ss_valid, input cs_valid, input tok, input out_data,
              input sof, output ready, output resp_valid, output resp, output in_data);
endinterface

/* inc/stt_params.svh */
// constants shared by both ends of the split transaction translator
`ifndef STT_PARAMS_SVH
`define STT_PARAMS_SVH
`define STT_CLK_HZ 20000000
`define STT_UFRAME_NS 125000
`define STT_UFRAME_CYC ((`STT_UFRAME_NS * 20) / 1000)
`define STT_UFRAMES_PER_FRAME 8
`define STT_FRAME_GUARD_CYC 16'h00C8
`define STT_FS_XACT_CYC 8'h20
`define STT_PER_DEPTH 4
`define STT_NP_DEPTH 2
`define STT_ADDR_W 7
`define STT_DATA_W 32
`define STT_HUB_ADDR_RST 7'h01
`endif

/* inc/stt_pkg.sv */
// types shared by both ends of the split transaction translator
package stt_pkg;
  typedef enum logic [1:0] {
    XFER_ISO  = 2'h0,
    XFER_INT  = 2'h1,
    XFER_BULK = 2'h2,
    XFER_CTRL = 2'h3
  } xfer_t;
  typedef enum logic [2:0] {
    RESP_NONE  = 3'h0,
    RESP_ACK   = 3'h1,
    RESP_NAK   = 3'h2,
    RESP_NYET  = 3'h3,
    RESP_STALL = 3'h4,
    RESP_ERR   = 3'h5,
    RESP_DATA  = 3'h6
  } resp_t;
  typedef struct packed {
    logic [6:0] hub_addr;
    logic [6:0] dev_addr;
    logic [3:0] endp;
    xfer_t xfer;
    logic is_in;
    logic low_speed;
  } split_tok_t;
endpackage

/* tb/split_transaction_translator_bench.sv */
// self-checking bench joining host and translator ends
`timescale 1ns/1ps
module split_transaction_translator_bench;
  localparam logic [6:0] HUB = 7'h05;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic multi_tt_i = 1'b0;
  logic req_ss_i = 1'b0;
  logic req_cs_i = 1'b0;
  stt_pkg::split_tok_t req_tok_i = '0;
  logic [31:0] req_data_i = 32'h0;
  logic busy_o, res_valid_o, multi_tt_o, fs_start_o, fs_pre_o;
  stt_pkg::resp_t res_o;
  stt_pkg::resp_t r;
  logic [31:0] res_data_o, fs_data_o, d;
  stt_pkg::split_tok_t fs_tok_o, cur, other_hub;
  logic fs_done_i = 1'b0;
  stt_pkg::resp_t fs_resp_i = stt_pkg::RESP_NONE;
  logic [31:0] fs_in_data_i = 32'h0;
  int error_cnt = 0;
  int num_checks = 0;
  int fs_left = 0;
  stt_pkg::split_tok_t starts[$];
  logic pres[$];
  logic [31:0] datas[$];
  stt_if link ();
  always #25 core_clk_i = ~core_clk_i;
  stt_host stt_host_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .dn(link),
    .req_ss_i(req_ss_i), .req_cs_i(req_cs_i), .req_tok_i(req_tok_i), .req_data_i(req_data_i),
    .busy_o(busy_o), .res_valid_o(res_valid_o), .res_o(res_o), .res_data_o(res_data_o));
  stt_tt stt_tt_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .up(link), .hub_addr_i(HUB),
    .multi_tt_i(multi_tt_i), .multi_tt_o(multi_tt_o), .fs_start_o(fs_start_o),
    .fs_tok_o(fs_tok_o), .fs_data_o(fs_data_o), .fs_pre_o(fs_pre_o), .fs_done_i(fs_done_i),
    .fs_resp_i(fs_resp_i), .fs_in_data_i(fs_in_data_i));
  stt_link_monitor #(.HUB_ADDR(HUB)) stt_link_monitor_i (.core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i), .ss_valid(link.ss_valid), .cs_valid(link.cs_valid), .tok(link.tok),
    .out_data(link.out_data), .sof(link.sof), .ready(link.ready),
    .resp_valid(link.resp_valid), .resp(link.resp), .in_data(link.in_data));
  function automatic logic [31:0] pat(input logic [6:0] dev);
    pat = {25'h0A5A5A5, dev};
  endfunction
  function automatic stt_pkg::split_tok_t mk(input logic [6:0] dev, input stt_pkg::xfer_t x,
                                             input logic in, input logic ls);
    mk = '{hub_addr: HUB, dev_addr: dev, endp: 4'h1, xfer: x, is_in: in, low_speed: ls};
  endfunction
  // slow bus model: one transaction at a time, data line toggles when idle
  always @(posedge core_clk_i) begin
    #1;
    fs_done_i = (fs_left == 1);
    fs_in_data_i = (fs_left == 1) ? (cur.is_in ? pat(cur.dev_addr) : 32'h0) : ~fs_in_data_i;
    if (fs_left == 1) fs_resp_i = cur.is_in ? stt_pkg::RESP_DATA : stt_pkg::RESP_ACK;
    if (fs_left > 0) fs_left--;
    if (fs_start_o === 1'b1) begin
      cur = fs_tok_o;
      fs_left = 8;
      starts.push_back(fs_tok_o);
      pres.push_back(fs_pre_o);
      datas.push_back(fs_data_o);
    end
  end
  task automatic finish_test();
    if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick();
    @(posedge core_clk_i);
    #1;
  endtask
  // issue one split, then watch a fixed window for its result
  task automatic split(input logic cs, input stt_pkg::split_tok_t t, input logic [31:0] wd);
    int n;
    n = 0;
    while (busy_o !== 1'b0) begin
      tick();
      n++;
      if (n > 100) begin
        error_cnt++;
        finish_test();
      end
    end
    req_ss_i = !cs;
    req_cs_i = cs;
    req_tok_i = t;
    req_data_i = wd;
    tick();
    req_ss_i = 1'b0;
    req_cs_i = 1'b0;
    r = stt_pkg::RESP_NONE;
    d = 32'h0;
    repeat (20) begin
      if (res_valid_o === 1'b1) begin
        r = res_o;
        d = res_data_o;
      end
      tick();
    end
  endtask
  // the first frame start comes with the first microframe start, so the bound is wide
  task automatic wait_starts(input int k);
    int n;
    n = 0;
    while (starts.size() < k) begin
      tick();
      n++;
      if (n > 30000) begin
        error_cnt++;
        finish_test();
      end
    end
    repeat (12) tick();
  endtask
  initial begin
    repeat (8) @(posedge core_clk_i);
    #1 rst_n_i = 1'b1;
    chk(multi_tt_o, 1'b0);
    multi_tt_i = 1'b1;
    repeat (2) tick();
    chk(multi_tt_o, 1'b1);
    tick();
    other_hub = mk(7'h11, stt_pkg::XFER_BULK, 0, 0);
    other_hub.hub_addr = 7'h06;
    split(0, other_hub, 32'h0);
    chk(r, stt_pkg::RESP_NONE);
    split(0, mk(7'h11, stt_pkg::XFER_BULK, 0, 0), 32'h12345678);
    chk(r, stt_pkg::RESP_ACK);
    split(0, mk(7'h12, stt_pkg::XFER_BULK, 1, 0), 32'h0);
    chk(r, stt_pkg::RESP_ACK);
    split(0, mk(7'h13, stt_pkg::XFER_CTRL, 0, 0), 32'h0);
    chk(r, stt_pkg::RESP_NAK);
    split(1, mk(7'h11, stt_pkg::XFER_BULK, 0, 0), 32'h0);
    chk(r, stt_pkg::RESP_NYET);
    wait_starts(2);
    chk(starts[0].dev_addr, 7'h11);
    chk(starts[1].dev_addr, 7'h12);
    chk(datas[0], 32'h12345678);
    split(1, mk(7'h12, stt_pkg::XFER_BULK, 1, 0), 32'h0);
    chk(r, stt_pkg::RESP_DATA);
    chk(d, pat(7'h12));
    split(1, mk(7'h11, stt_pkg::XFER_BULK, 0, 0), 32'h0);
    chk(r, stt_pkg::RESP_ACK);
    split(1, mk(7'h11, stt_pkg::XFER_BULK, 0, 0), 32'h0);
    chk(r, stt_pkg::RESP_NYET);
    split(0, mk(7'h21, stt_pkg::XFER_INT, 1, 1), 32'h0);
    chk(r, stt_pkg::RESP_ACK);
    split(0, mk(7'h22, stt_pkg::XFER_INT, 1, 0), 32'h0);
    chk(r, stt_pkg::RESP_ACK);
    split(0, mk(7'h23, stt_pkg::XFER_ISO, 0, 0), 32'hCAFE0023);
    chk(r, stt_pkg::RESP_NONE);
    wait_starts(5);
    for (int i = 0; i < 3; i++) begin
      chk(starts[2 + i].dev_addr, 7'h21 + i);
      chk(pres[2 + i], i == 0);
    end
    chk(datas[4], 32'hCAFE0023);
    split(1, mk(7'h21, stt_pkg::XFER_INT, 1, 1), 32'h0);
    chk(r, stt_pkg::RESP_DATA);
    chk(d, pat(7'h21));
    split(1, mk(7'h22, stt_pkg::XFER_INT, 1, 0), 32'h0);
    chk(r, stt_pkg::RESP_DATA);
    chk(d, pat(7'h22));
    split(1, mk(7'h23, stt_pkg::XFER_ISO, 0, 0), 32'h0);
    chk(r, stt_pkg::RESP_ACK);
    split(1, mk(7'h23, stt_pkg::XFER_ISO, 0, 0), 32'h0);
    chk(r, stt_pkg::RESP_NYET);
    finish_test();
  end
endmodule // split_transaction_translator_bench

/* tb/stt_link_monitor.sv */
// assertions on the split link between host and translator
`timescale 1ns/1ps
module stt_link_monitor #(
  parameter logic [6:0] HUB_ADDR = 7'h01
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // host to translator
  input wire logic ss_valid,
  input wire logic cs_valid,
  input wire stt_pkg::split_tok_t tok,
  input wire logic [31:0] out_data,
  input wire logic sof,
  // translator to host
  input wire logic ready,
  input wire logic resp_valid,
  input wire stt_pkg::resp_t resp,
  input wire logic [31:0] in_data
);
  logic mine;
  assign mine = tok.hub_addr == HUB_ADDR;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_ss_answered: assert property (
    ss_valid && mine && tok.xfer != stt_pkg::XFER_ISO |=>
      resp_valid && resp inside {stt_pkg::RESP_ACK, stt_pkg::RESP_NAK})
    else $error("start-split not answered with ACK or NAK");
  chk_iso_silent: assert property (
    ss_valid && mine && tok.xfer == stt_pkg::XFER_ISO |=> !resp_valid)
    else $error("isochronous start-split answered");
  chk_int_acked: assert property (
    ss_valid && mine && tok.xfer == stt_pkg::XFER_INT |=> resp == stt_pkg::RESP_ACK)
    else $error("interrupt start-split not acknowledged");
  chk_cs_answered: assert property (
    cs_valid && mine |=> resp_valid && resp != stt_pkg::RESP_NONE)
    else $error("complete-split not answered");
  chk_foreign_ignored: assert property (
    (ss_valid || cs_valid) && !mine |=> !resp_valid)
    else $error("split for another hub answered");
  chk_resp_caused: assert property (
    resp_valid |-> $past(ss_valid || cs_valid))
    else $error("answer without a split one cycle earlier");
  chk_in_data_hold: assert property (
    !(resp_valid && $past(cs_valid)) |-> $stable(in_data))
    else $error("result data changed outside a complete-split answer");
  chk_one_split: assert property (
    ss_valid || cs_valid |=> !(ss_valid || cs_valid) [*2])
    else $error("host issued splits without waiting");
  chk_sof_single: assert property (
    sof |=> !sof [*8])
    else $error("microframe start wider than one cycle");
  chk_ready_up: assert property (
    resp_valid |-> ready && resp != stt_pkg::RESP_NONE)
    else $error("answer without a code or link not ready");
endmodule // stt_link_monitor

/* verilog/stt_frame_timer.sv */
// frame timer slaved to upstream microframe starts
`timescale 1ns/1ps
`include "stt_params.svh"
module stt_frame_timer (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // microframe start from the high-speed side
  input wire logic uframe_i,
  // frame timing
  output logic frame_start_o,
  output logic time_ok_o
);
  logic [2:0] uf, next_uf;
  logic [15:0] left, next_left;
  logic fs, next_fs;
  localparam logic [15:0] FRAME_CYC = 16'(`STT_UFRAME_CYC * `STT_UFRAMES_PER_FRAME);
  always_comb begin
    next_uf = uf;
    next_left = (left != 16'h0000) ? left - 16'h0001 : left;
    next_fs = 1'b0;
    if (uframe_i) begin
      next_uf = uf + 3'h1;
      if (uf == 3'h7) begin
        next_fs = 1'b1;
        next_left = FRAME_CYC;
      end
    end
  end
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      uf <= 3'h7;
      left <= 16'h0000;
      fs <= 1'b0;
    end else begin
      uf <= next_uf;
      left <= next_left;
      fs <= next_fs;
    end
  end
  assign frame_start_o = fs;
  // guard keeps a bulk transaction from running past the frame end
  assign time_ok_o = left > `STT_FRAME_GUARD_CYC;
endmodule // stt_frame_timer

/* verilog/stt_host.sv */
// host controller end: issues start- and complete-splits
`timescale 1ns/1ps
`include "stt_params.svh"
module stt_host (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // high-speed link
  stt_if.host dn,
  // user requests
  input wire logic req_ss_i,
  input wire logic req_cs_i,
  input wire stt_pkg::split_tok_t req_tok_i,
  input wire logic [31:0] req_data_i,
  output logic busy_o,
  // results
  output logic res_valid_o,
  output stt_pkg::resp_t res_o,
  output logic [31:0] res_data_o
);
  localparam logic [15:0] UF_CYC = 16'(`STT_UFRAME_CYC);
  logic [15:0] uf_cnt, next_uf_cnt;
  logic ss, next_ss, cs, next_cs, sof, next_sof, wait_r, next_wait_r;
  stt_pkg::split_tok_t tok, next_tok;
  logic [31:0] dat, next_dat;
  logic rv, next_rv;
  stt_pkg::resp_t r, next_r;
  logic [31:0] rd, next_rd;
  always_comb begin
    next_uf_cnt = (uf_cnt == UF_CYC - 16'h0001) ? 16'h0000 : uf_cnt + 16'h0001;
    next_sof = uf_cnt == UF_CYC - 16'h0001;
    next_ss = 1'b0;
    next_cs = 1'b0;
    next_tok = tok;
    next_dat = dat;
    next_wait_r = wait_r;
    next_rv = 1'b0;
    next_r = r;
    next_rd = rd;
    if (!wait_r && (req_ss_i || req_cs_i)) begin
      // host feeds the stores; user paces splits
      next_ss = req_ss_i;
      next_cs = !req_ss_i;
      next_tok = req_tok_i;
      next_dat = req_data_i;
      next_wait_r = 1'b1;
    end else if (wait_r && dn.resp_valid) begin
      next_rv = 1'b1;
      next_r = dn.resp;
      next_rd = dn.in_data;
      next_wait_r = 1'b0;
    end else if (wait_r && !ss && !cs) begin
      // answer is due one cycle after the split; none means iso or another hub
      next_wait_r = 1'b0;
    end
  end
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      uf_cnt <= 16'h0000;
      sof <= 1'b0;
      ss <= 1'b0;
      cs <= 1'b0;
      tok <= '0;
      dat <= 32'h0000_0000;
      wait_r <= 1'b0;
      rv <= 1'b0;
      r <= stt_pkg::RESP_NONE;
      rd <= 32'h0000_0000;
    end else begin
      uf_cnt <= next_uf_cnt;
      sof <= next_sof;
      ss <= next_ss;
      cs <= next_cs;
      tok <= next_tok;
      dat <= next_dat;
      wait_r <= next_wait_r;
      rv <= next_rv;
      r <= next_r;
      rd <= next_rd;
    end
  end
  assign dn.ss_valid = ss;
  assign dn.cs_valid = cs;
  assign dn.tok = tok;
  assign dn.out_data = dat;
  assign dn.sof = sof;
  assign busy_o = wait_r;
  assign res_valid_o = rv;
  assign res_o = r;
  assign res_data_o = rd;
endmodule // stt_host

/* verilog/stt_tt.sv */
// translator end: high-speed handler, buffers and full/low-speed handler
// Summary of operation
// - isolate high-speed from full/low-speed signaling
// - high-speed function upstream, host downstream
// - accept start-splits, answer complete-splits from buffers
// - store each downstream outcome for complete-split
// - handlers meet only through shared buffers
// - separate periodic and non-periodic sections
// - track state per buffered transaction by type
// - no preamble upstream; low speed in token
// - splits only between host and hub
// - buffer start-split; handshake only where defined
// - periodic start-splits served in arrival order
// - periodic complete-split answered from buffer head result, non-periodic from the buffer matching device and endpoint
// - report shared or per-port organization
// - outbound entries keep payload, inbound do not
// - periodic start and complete stores separate
// - host keeps periodic stores fed and drained
// - host sends just in time, collects promptly
// - host issues complete-split later for result
// - refuse non-periodic start-split with NAK when full
// - bulk/control served round robin with time left
// - frame timer follows upstream microframes
`timescale 1ns/1ps
`include "stt_params.svh"
module stt_tt (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // high-speed upstream link
  stt_if.tt up,
  // configuration
  input wire logic [6:0] hub_addr_i,
  input wire logic multi_tt_i,
  output logic multi_tt_o,
  // full/low-speed downstream bus
  output logic fs_start_o,
  output stt_pkg::split_tok_t fs_tok_o,
  output logic [31:0] fs_data_o,
  output logic fs_pre_o,
  input wire logic fs_done_i,
  input wire stt_pkg::resp_t fs_resp_i,
  input wire logic [31:0] fs_in_data_i
);
  localparam int PD = `STT_PER_DEPTH;
  localparam int ND = `STT_NP_DEPTH;
  typedef enum logic [2:0] {ST_OLD = 3'b001, ST_PEND = 3'b010, ST_READY = 3'b100} ent_t;
  typedef enum logic [2:0] {FS_IDLE = 3'b001, FS_PER = 3'b010, FS_NP = 3'b100} fs_t;
  // periodic start-split store and complete-split store
  stt_pkg::split_tok_t ss_tok [PD];
  logic [31:0] ss_dat [PD];
  logic [1:0] ss_wp, ss_rp, next_ss_wp, next_ss_rp;
  logic [2:0] ss_cnt, next_ss_cnt;
  stt_pkg::resp_t cs_res [PD];
  logic [31:0] cs_dat [PD];
  logic [1:0] cs_wp, cs_rp, next_cs_wp, next_cs_rp;
  logic [2:0] cs_cnt, next_cs_cnt;
  // non-periodic buffers, each reused for its result
  stt_pkg::split_tok_t np_tok [ND];
  logic [31:0] np_dat [ND];
  stt_pkg::resp_t np_res [ND];
  ent_t np_st [ND], next_np_st [ND];
  logic np_rr, next_np_rr, np_sel, next_np_sel;
  fs_t fs, next_fs;
  logic resp_v, next_resp_v;
  stt_pkg::resp_t resp, next_resp;
  logic [31:0] rdat, next_rdat;
  logic fsgo, next_fsgo;
  stt_pkg::split_tok_t ftok, next_ftok;
  logic [31:0] fdat, next_fdat;
  logic time_ok, for_me, per, org_meta, org;
  logic np_free, np_fslot, np_cs_hit, np_cs_idx, np_pick, np_any;
  function automatic logic is_per(input stt_pkg::xfer_t x);
    return (x == stt_pkg::XFER_ISO) || (x == stt_pkg::XFER_INT);
  endfunction
  stt_frame_timer timer (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .uframe_i(up.sof),
    .frame_start_o(),
    .time_ok_o(time_ok)
  );
  assign for_me = up.tok.hub_addr == hub_addr_i;
  assign per = is_per(up.tok.xfer);
  always_comb begin
    np_free = 1'b0;
    np_fslot = 1'b0;
    np_cs_hit = 1'b0;
    np_cs_idx = 1'b0;
    np_any = 1'b0;
    np_pick = np_rr;
    for (int i = ND - 1; i >= 0; i--) begin
      if (np_st[i] == ST_OLD) begin
        np_free = 1'b1;
        np_fslot = 1'(i);
      end
      if (np_st[i] != ST_OLD && np_tok[i].dev_addr == up.tok.dev_addr &&
          np_tok[i].endp == up.tok.endp) begin
        np_cs_hit = 1'b1;
        np_cs_idx = 1'(i);
      end
    end
    if (np_st[np_rr] == ST_PEND) begin
      np_any = 1'b1;
      np_pick = np_rr;
    end else if (np_st[~np_rr] == ST_PEND) begin
      np_any = 1'b1;
      np_pick = ~np_rr;
    end
  end
  // upstream (high-speed) handler; only touches the stores
  always_comb begin
    next_ss_wp = ss_wp;
    next_ss_rp = ss_rp;
    next_ss_cnt = ss_cnt;
    next_cs_wp = cs_wp;
    next_cs_rp = cs_rp;
    next_cs_cnt = cs_cnt;
    next_resp_v = 1'b0;
    next_resp = stt_pkg::RESP_NONE;
    next_rdat = rdat;
    next_np_st = np_st;
    next_np_rr = np_rr;
    next_np_sel = np_sel;
    next_fs = fs;
    next_fsgo = 1'b0;
    next_ftok = ftok;
    next_fdat = fdat;
    if (up.ss_valid && for_me) begin
      if (per) begin
        if (ss_cnt != 3'(PD)) begin
          next_ss_wp = ss_wp + 2'h1;
          next_ss_cnt = next_ss_cnt + 3'h1;
        end
        // isochronous start-splits carry no handshake phase
        next_resp_v = up.tok.xfer == stt_pkg::XFER_INT;
        next_resp = stt_pkg::RESP_ACK;
      end else begin
        next_resp_v = 1'b1;
        if (np_free) begin
          next_np_st[np_fslot] = ST_PEND;
          next_resp = stt_pkg::RESP_ACK;
        end else begin
          next_resp = stt_pkg::RESP_NAK;
        end
      end
    end else if (up.cs_valid && for_me) begin
      next_resp_v = 1'b1;
      if (per) begin
        if (cs_cnt != 3'h0) begin
          next_resp = cs_res[cs_rp];
          next_rdat = cs_dat[cs_rp];
          next_cs_rp = cs_rp + 2'h1;
          next_cs_cnt = next_cs_cnt - 3'h1;
        end else begin
          next_resp = stt_pkg::RESP_NYET;
        end
      end else if (np_cs_hit && np_st[np_cs_idx] == ST_READY) begin
        next_resp = np_res[np_cs_idx];
        next_rdat = np_dat[np_cs_idx];
        next_np_st[np_cs_idx] = ST_OLD;
      end else begin
        next_resp = stt_pkg::RESP_NYET;
      end
    end
    // downstream handler: acts as host on the slow bus
    case (fs)
      FS_IDLE: begin
        if (ss_cnt != 3'h0 && cs_cnt != 3'(PD)) begin
          next_fsgo = 1'b1;
          next_ftok = ss_tok[ss_rp];
          next_fdat = ss_dat[ss_rp];
          next_ss_rp = ss_rp + 2'h1;
          next_ss_cnt = next_ss_cnt - 3'h1;
          next_fs = FS_PER;
        end else if (np_any && time_ok) begin
          next_fsgo = 1'b1;
          next_ftok = np_tok[np_pick];
          next_fdat = np_dat[np_pick];
          next_np_sel = np_pick;
          next_np_rr = ~np_pick;
          next_fs = FS_NP;
        end
      end
      FS_PER: begin
        if (fs_done_i) begin
          next_cs_wp = cs_wp + 2'h1;
          next_cs_cnt = next_cs_cnt + 3'h1;
          next_fs = FS_IDLE;
        end
      end
      FS_NP: begin
        if (fs_done_i) begin
          next_np_st[np_sel] = ST_READY;
          next_fs = FS_IDLE;
        end
      end
      default: next_fs = FS_IDLE;
    endcase
  end
  // buffer contents: payload kept for outbound only
  always_ff @(posedge core_clk_i) begin
    if (up.ss_valid && for_me && per && ss_cnt != 3'(PD)) begin
      ss_tok[ss_wp] <= up.tok;
      ss_dat[ss_wp] <= up.tok.is_in ? 32'h0000_0000 : up.out_data;
    end
    if (up.ss_valid && for_me && !per && np_free) begin
      np_tok[np_fslot] <= up.tok;
      np_dat[np_fslot] <= up.tok.is_in ? 32'h0000_0000 : up.out_data;
    end
    if (fs == FS_PER && fs_done_i) begin
      cs_res[cs_wp] <= fs_resp_i;
      cs_dat[cs_wp] <= fs_in_data_i;
    end
    if (fs == FS_NP && fs_done_i) begin
      np_res[np_sel] <= fs_resp_i;
      np_dat[np_sel] <= fs_in_data_i;
    end
  end
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ss_wp <= 2'h0;
      ss_rp <= 2'h0;
      ss_cnt <= 3'h0;
      cs_wp <= 2'h0;
      cs_rp <= 2'h0;
      cs_cnt <= 3'h0;
      np_st <= '{default: ST_OLD};
      np_rr <= 1'b0;
      org_meta <= 1'b0;
      org <= 1'b0;
      np_sel <= 1'b0;
      fs <= FS_IDLE;
      resp_v <= 1'b0;
      resp <= stt_pkg::RESP_NONE;
      rdat <= 32'h0000_0000;
      fsgo <= 1'b0;
      ftok <= '0;
      fdat <= 32'h0000_0000;
    end else begin
      ss_wp <= next_ss_wp;
      ss_rp <= next_ss_rp;
      ss_cnt <= next_ss_cnt;
      cs_wp <= next_cs_wp;
      cs_rp <= next_cs_rp;
      cs_cnt <= next_cs_cnt;
      np_st <= next_np_st;
      np_rr <= next_np_rr;
      np_sel <= next_np_sel;
      fs <= next_fs;
      resp_v <= next_resp_v;
      resp <= next_resp;
      rdat <= next_rdat;
      fsgo <= next_fsgo;
      ftok <= next_ftok;
      fdat <= next_fdat;
      org_meta <= multi_tt_i;
      org <= org_meta;
    end
  end
  // upstream and downstream ports never share a wire
  assign up.ready = 1'b1;
  assign up.resp_valid = resp_v;
  assign up.resp = resp;
  assign up.in_data = rdat;
  assign fs_start_o = fsgo;
  assign fs_tok_o = ftok;
  assign fs_data_o = fdat;
  // preamble only downstream, decoded from the token
  assign fs_pre_o = fsgo & ftok.low_speed;
  assign multi_tt_o = org; // strap comes from a pin, so two flops first
endmodule // stt_tt
